//--- hw/pdesel_cfg.svh
// Purpose: Named offsets, field positions, codes and reset values of the pin function slice.
// Assumes: Registers are reached over a plain strobe port with a 4-bit byte address.
// Notes:   Definitions only; included by the package and the design modules.
`ifndef PDESEL_CFG_SVH
`define PDESEL_CFG_SVH

// Pin counts of the two ports handled here, and the register port data and address widths.
`define PDESEL_PD_PINS       7
`define PDESEL_PE_PINS       16
`define PDESEL_PE_LOW_PINS   14
`define PDESEL_DATA_W        16
`define PDESEL_ADDR_W        4

// Register byte addresses.
`define PDESEL_ADDR_PD_FS    4'h0
`define PDESEL_ADDR_PE_DIR   4'h2
`define PDESEL_ADDR_PE_FS1   4'h4

// Field positions inside the upper port E function register.
`define PDESEL_FS1_MSB       15
`define PDESEL_FS1_LSB       12
`define PDESEL_FS1_W         4
`define PDESEL_E14_LSB       0
`define PDESEL_E15_LSB       2

// Two-bit function codes of the upper port E pins.
`define PDESEL_CODE_GPIO     2'h0
`define PDESEL_CODE_DACK     2'h2
`define PDESEL_CODE_AH       2'h3

// Operating mode pin codes.
`define PDESEL_MODE_ROM_OFF8  2'h0
`define PDESEL_MODE_ROM_OFF16 2'h1
`define PDESEL_MODE_ROM_ON    2'h2
`define PDESEL_MODE_SINGLE    2'h3

// Reset values, applied only by the power-on reset.
`define PDESEL_RST_PD_FS     7'h00
`define PDESEL_RST_PE_DIR    16'h0000
`define PDESEL_RST_PE_FS1    4'h0
`define PDESEL_RST_WORD      16'h0000
`define PDESEL_RD_ZERO       16'h0000

`endif

//--- hw/pdesel_pkg.sv
// Purpose: Types shared by the pin function slice.
// Assumes: The constants header supplies every struct field width; the mode enum is 2 bits wide in place.
// Notes:   Nothing here is imported; users write pdesel_pkg::name.
`include "pdesel_cfg.svh"

package pdesel_pkg;

   // Chip operating modes as seen by the port D routing.
   typedef enum logic [1:0] {
      ROM_OFF_8,
      ROM_OFF_16,
      ROM_ON_EXT,
      SINGLE_CHIP
   } pdesel_op_mode_type;

   // Whole state of the top module: registers and registered pin outputs.
   typedef struct packed {
      logic [`PDESEL_PD_PINS-1:0]     pd_fs;
      logic [`PDESEL_PE_PINS-1:0]     pe_dir;
      logic [`PDESEL_FS1_W-1:0]       pe_fs1;
      logic [`PDESEL_DATA_W-1:0]      rdata;
      logic [`PDESEL_PD_PINS-1:0]     pd_pin;
      logic [`PDESEL_PD_PINS-1:0]     pd_oe;
      logic [`PDESEL_PD_PINS-1:0]     pd_gpio_in;
      logic [`PDESEL_PD_PINS-1:0]     pd_bus_in;
      logic [`PDESEL_PD_PINS-1:0]     pd_bus_sel;
      logic [`PDESEL_PE_PINS-1:0]     pe_pin;
      logic [`PDESEL_PE_PINS-1:0]     pe_oe;
      logic [`PDESEL_PE_PINS-1:0]     pe_gpio_in;
      logic [`PDESEL_PE_LOW_PINS-1:0] pe_timer_in;
   } pdesel_top_state_type;

endpackage

//--- hw/pdesel_sync.sv
// Purpose: Two-stage synchroniser for levels arriving from pins.
// Assumes: Inputs are slow levels; no pulse shorter than two clocks matters.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps

module pdesel_sync #(
   parameter int              WIDTH = 1,
   parameter logic [WIDTH-1:0] RST  = '0
) (
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } pdesel_sync_state_type;

   pdesel_sync_state_type s_r;
   pdesel_sync_state_type s_nxt;

   // The first stage feeds only the second stage.
   always_comb begin
      s_nxt.stage1 = async_i;
      s_nxt.stage2 = s_r.stage1;
   end

   // Both stages reset to the chosen quiet level.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_r <= {RST, RST};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sync_o = s_r.stage2;

endmodule

//--- hw/pdesel_e_route.sv
// Purpose: Function decode of one upper port E pin from its two-bit code.
// Assumes: Called with the code that the register holds after the current edge.
// Notes:   Purely combinational; the top registers every result.
`timescale 1ns/1ps
`include "pdesel_cfg.svh"

module pdesel_e_route #(
   parameter bit ALLOW_AH = 1'b0
) (
   input  wire logic [1:0] fcode_i,
   input  wire logic       single_chip_i,
   input  wire logic       gpio_out_i,
   input  wire logic       gpio_dir_i,
   input  wire logic       dack_i,
   input  wire logic       ah_i,
   output logic            pin_out_o,
   output logic            pin_oe_o
);

   logic use_dack;
   logic use_ah;

   // Reserved codes and single-chip mode fall back to general I/O.
   assign use_dack = (fcode_i == `PDESEL_CODE_DACK) && !single_chip_i;
   assign use_ah   = ALLOW_AH && (fcode_i == `PDESEL_CODE_AH) && !single_chip_i;

   // Peripheral outputs always drive; the direction bit counts only for general I/O.
   always_comb begin
      pin_out_o = gpio_out_i;
      pin_oe_o  = gpio_dir_i;
      if (use_dack) begin
         pin_out_o = dack_i;
         pin_oe_o  = 1'b1;
      end else if (use_ah) begin
         pin_out_o = ah_i;
         pin_oe_o  = 1'b1;
      end
   end

endmodule

//--- hw/pdesel_top.sv
// Purpose: Pin function slice for port D pins 6..0 and the port E direction and upper functions.
// Assumes: arst_n_i is the external power-on reset; watchdog, standby and sleep never reach it.
// Notes:   Pin outputs are registered and follow a register write on the same clock edge.
//
// Summary of operation
// - Port D mode bits 6..0 pick each pin's function; 0 means general I/O.
// - A port D mode bit of 1 makes the pin a data bus line.
// - With on-chip ROM disabled, port D pins are data bus lines regardless.
// - In single-chip mode, port D pins stay general I/O regardless.
// - Port E direction register is 16-bit read/write, one bit per pin.
// - A direction bit counts only for general I/O or timer pin functions.
// - An effective direction bit of 1 means output, 0 means input.
// - Port E direction clears to zero only on power-on reset.
// - Port E function registers clear to zero only on power-on reset.
// - Upper function register serves pins 15 and 14; both registers are 16-bit.
// - Single-chip mode may override acknowledge and address-hold, leaving general I/O.
// - Bits 15:14 pick pin 15: 00 general I/O, 10 channel 1 acknowledge.
// - Bits 13:12 pick pin 14: 00 I/O, 10 channel 0 acknowledge, 11 address hold.
// - Upper function register bits 11..0 read zero; software writes only zero.
// - Port D mode bits matter only in ROM-enabled extended mode.
// - Port D function register clears only on power-on reset.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "pdesel_cfg.svh"

module pdesel_top (
   input  wire logic                           clk_i,
   input  wire logic                           arst_n_i,
   // Register port.
   input  wire logic [`PDESEL_ADDR_W-1:0]      reg_addr_i,
   input  wire logic [`PDESEL_DATA_W-1:0]      reg_wdata_i,
   input  wire logic                           reg_wr_i,
   input  wire logic                           reg_rd_i,
   output logic      [`PDESEL_DATA_W-1:0]      reg_rdata_o,
   // Operating mode pins.
   input  wire logic [1:0]                     op_mode_pins_i,
   // Port D pins 6..0 and their two users.
   input  wire logic [`PDESEL_PD_PINS-1:0]     pd_pin_i,
   input  wire logic [`PDESEL_PD_PINS-1:0]     pd_gpio_out_i,
   input  wire logic [`PDESEL_PD_PINS-1:0]     pd_gpio_dir_i,
   input  wire logic [`PDESEL_PD_PINS-1:0]     pd_bus_out_i,
   input  wire logic                           pd_bus_drive_i,
   output logic      [`PDESEL_PD_PINS-1:0]     pd_pin_o,
   output logic      [`PDESEL_PD_PINS-1:0]     pd_pin_oe_o,
   output logic      [`PDESEL_PD_PINS-1:0]     pd_gpio_in_o,
   output logic      [`PDESEL_PD_PINS-1:0]     pd_bus_in_o,
   output logic      [`PDESEL_PD_PINS-1:0]     pd_bus_sel_o,
   // Port E pins 15..0 and their users.
   input  wire logic [`PDESEL_PE_PINS-1:0]     pe_pin_i,
   input  wire logic [`PDESEL_PE_PINS-1:0]     pe_gpio_out_i,
   input  wire logic [`PDESEL_PE_LOW_PINS-1:0] pe_timer_sel_i,
   input  wire logic [`PDESEL_PE_LOW_PINS-1:0] pe_timer_out_i,
   input  wire logic                           dma_ch0_acknowledge_out_i,
   input  wire logic                           dma_ch1_acknowledge_out_i,
   input  wire logic                           address_hold_out_i,
   output logic      [`PDESEL_PE_PINS-1:0]     pe_pin_o,
   output logic      [`PDESEL_PE_PINS-1:0]     pe_pin_oe_o,
   output logic      [`PDESEL_PE_PINS-1:0]     pe_gpio_in_o,
   output logic      [`PDESEL_PE_LOW_PINS-1:0] pe_timer_in_o
);

   localparam int PD_N   = `PDESEL_PD_PINS;
   localparam int PE_N   = `PDESEL_PE_PINS;
   localparam int PE_LOW = `PDESEL_PE_LOW_PINS;
   localparam int SYNC_W = 2 + PD_N + PE_N;

   pdesel_pkg::pdesel_top_state_type s_r;
   pdesel_pkg::pdesel_top_state_type s_nxt;

   logic [SYNC_W-1:0]           sync_q;
   logic [1:0]                  mode_pins_s;
   logic [PD_N-1:0]             pd_pin_s;
   logic [PE_N-1:0]             pe_pin_s;
   pdesel_pkg::pdesel_op_mode_type op_mode;
   logic                        single_chip;
   logic                        rom_off;
   logic                        wr_pd_fs;
   logic                        wr_pe_dir;
   logic                        wr_pe_fs1;
   logic [PD_N-1:0]             pd_fs_nxt;
   logic [PE_N-1:0]             pe_dir_nxt;
   logic [`PDESEL_FS1_W-1:0]    pe_fs1_nxt;
   logic [PD_N-1:0]             pd_sel;
   logic [1:0]                  hi_out;
   logic [1:0]                  hi_oe;

   // All pin levels and the mode pins cross into the clock domain here.
   pdesel_sync #(
      .WIDTH (SYNC_W),
      .RST   ({SYNC_W{1'b0}})
   ) u_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .async_i  ({op_mode_pins_i, pd_pin_i, pe_pin_i}),
      .sync_o   (sync_q)
   );

   assign mode_pins_s = sync_q[SYNC_W-1 -: 2];
   assign pd_pin_s    = sync_q[PE_N +: PD_N];
   assign pe_pin_s    = sync_q[PE_N-1:0];

   // Mode pin decode; every code is legal so no default is needed.
   always_comb begin
      op_mode = pdesel_pkg::ROM_OFF_8;
      unique case (mode_pins_s)
         `PDESEL_MODE_ROM_OFF8:  op_mode = pdesel_pkg::ROM_OFF_8;
         `PDESEL_MODE_ROM_OFF16: op_mode = pdesel_pkg::ROM_OFF_16;
         `PDESEL_MODE_ROM_ON:    op_mode = pdesel_pkg::ROM_ON_EXT;
         `PDESEL_MODE_SINGLE:    op_mode = pdesel_pkg::SINGLE_CHIP;
      endcase
   end

   assign single_chip = (op_mode == pdesel_pkg::SINGLE_CHIP);
   assign rom_off     = (op_mode == pdesel_pkg::ROM_OFF_8) || (op_mode == pdesel_pkg::ROM_OFF_16);

   // Address decode of the three registers.
   assign wr_pd_fs  = reg_wr_i && (reg_addr_i == `PDESEL_ADDR_PD_FS);
   assign wr_pe_dir = reg_wr_i && (reg_addr_i == `PDESEL_ADDR_PE_DIR);
   assign wr_pe_fs1 = reg_wr_i && (reg_addr_i == `PDESEL_ADDR_PE_FS1);

   // Next register contents, used by the routing so a write acts at once.
   assign pd_fs_nxt  = wr_pd_fs ? reg_wdata_i[PD_N-1:0] : s_r.pd_fs;
   assign pe_dir_nxt = wr_pe_dir ? reg_wdata_i : s_r.pe_dir;
   // Only the two function fields are stored; bits 11..0 have no storage.
   assign pe_fs1_nxt = wr_pe_fs1 ? reg_wdata_i[`PDESEL_FS1_MSB:`PDESEL_FS1_LSB]
                                 : s_r.pe_fs1;

   // Port D selection per pin: data bus when ROM is off, or in ROM-enabled extended mode when the bit is set.
   genvar gi;
   generate
      for (gi = 0; gi < PD_N; gi++) begin : g_pd
         assign pd_sel[gi] = !single_chip &&
                             (rom_off ||
                              ((op_mode == pdesel_pkg::ROM_ON_EXT) &&
                               pd_fs_nxt[gi]));
      end
   endgenerate

   // Pin 14 may carry channel 0 acknowledge or address hold.
   pdesel_e_route #(
      .ALLOW_AH (1'b1)
   ) u_route_e14 (
      .fcode_i       (pe_fs1_nxt[`PDESEL_E14_LSB +: 2]),
      .single_chip_i (single_chip),
      .gpio_out_i    (pe_gpio_out_i[PE_N-2]),
      .gpio_dir_i    (pe_dir_nxt[PE_N-2]),
      .dack_i        (dma_ch0_acknowledge_out_i),
      .ah_i          (address_hold_out_i),
      .pin_out_o     (hi_out[0]),
      .pin_oe_o      (hi_oe[0])
   );

   // Pin 15 may carry channel 1 acknowledge; code 11 is reserved there.
   pdesel_e_route #(
      .ALLOW_AH (1'b0)
   ) u_route_e15 (
      .fcode_i       (pe_fs1_nxt[`PDESEL_E15_LSB +: 2]),
      .single_chip_i (single_chip),
      .gpio_out_i    (pe_gpio_out_i[PE_N-1]),
      .gpio_dir_i    (pe_dir_nxt[PE_N-1]),
      .dack_i        (dma_ch1_acknowledge_out_i),
      .ah_i          (1'b0),
      .pin_out_o     (hi_out[1]),
      .pin_oe_o      (hi_oe[1])
   );

   // Next state: register contents, read data and every pin result.
   always_comb begin
      s_nxt        = s_r;
      s_nxt.pd_fs  = pd_fs_nxt;
      s_nxt.pe_dir = pe_dir_nxt;
      s_nxt.pe_fs1 = pe_fs1_nxt;

      // Read data stand for one cycle only; unmapped addresses read zero.
      s_nxt.rdata = `PDESEL_RD_ZERO;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            `PDESEL_ADDR_PD_FS: begin
               s_nxt.rdata[PD_N-1:0] = s_r.pd_fs;
            end
            `PDESEL_ADDR_PE_DIR: begin
               s_nxt.rdata = s_r.pe_dir;
            end
            `PDESEL_ADDR_PE_FS1: begin
               s_nxt.rdata[`PDESEL_FS1_MSB:`PDESEL_FS1_LSB] = s_r.pe_fs1;
            end
            default: begin
               s_nxt.rdata = `PDESEL_RD_ZERO;
            end
         endcase
      end

      // Port D routing: bus drive comes from the bus controller, else the port direction.
      s_nxt.pd_bus_sel = pd_sel;
      for (int i = 0; i < PD_N; i++) begin
         if (pd_sel[i]) begin
            s_nxt.pd_pin[i] = pd_bus_out_i[i];
            s_nxt.pd_oe[i]  = pd_bus_drive_i;
         end else begin
            s_nxt.pd_pin[i] = pd_gpio_out_i[i];
            s_nxt.pd_oe[i]  = pd_gpio_dir_i[i];
         end
      end
      s_nxt.pd_gpio_in = pd_pin_s;
      s_nxt.pd_bus_in  = pd_pin_s & pd_sel;

      // Port E lower pins: general I/O or timer pin, both under the direction bit.
      for (int i = 0; i < PE_LOW; i++) begin
         s_nxt.pe_pin[i] = pe_timer_sel_i[i] ? pe_timer_out_i[i] : pe_gpio_out_i[i];
         s_nxt.pe_oe[i]  = pe_dir_nxt[i];
      end
      s_nxt.pe_pin[PE_N-1 -: 2] = hi_out;
      s_nxt.pe_oe[PE_N-1 -: 2]  = hi_oe;
      s_nxt.pe_gpio_in  = pe_pin_s;
      s_nxt.pe_timer_in = pe_pin_s[PE_LOW-1:0] & pe_timer_sel_i;
   end

   // Only the power-on reset clears the state; no other reset reaches it.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_r             <= '0;
         s_r.pd_fs       <= `PDESEL_RST_PD_FS;
         s_r.pe_dir      <= `PDESEL_RST_PE_DIR;
         s_r.pe_fs1      <= `PDESEL_RST_PE_FS1;
         s_r.rdata       <= `PDESEL_RST_WORD;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state flip-flops.
   assign reg_rdata_o   = s_r.rdata;
   assign pd_pin_o      = s_r.pd_pin;
   assign pd_pin_oe_o   = s_r.pd_oe;
   assign pd_gpio_in_o  = s_r.pd_gpio_in;
   assign pd_bus_in_o   = s_r.pd_bus_in;
   assign pd_bus_sel_o  = s_r.pd_bus_sel;
   assign pe_pin_o      = s_r.pe_pin;
   assign pe_pin_oe_o   = s_r.pe_oe;
   assign pe_gpio_in_o  = s_r.pe_gpio_in;
   assign pe_timer_in_o = s_r.pe_timer_in;

endmodule

//--- tb/pdesel_monitor.sv
// Purpose: Port assertions for the pin function slice.
// Assumes: Register contents are mirrored from bus writes seen at the ports.
// Notes:   Bound to pdesel_top below the module.
`timescale 1ns/1ps
`include "pdesel_cfg.svh"

module pdesel_monitor (
   input wire logic        clk_i,
   input wire logic        arst_n_i,
   input wire logic [3:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic [1:0]  op_mode_pins_i,
   input wire logic [6:0]  pd_gpio_out_i,
   input wire logic [6:0]  pd_bus_out_i,
   input wire logic [6:0]  pd_pin_o,
   input wire logic [6:0]  pd_bus_sel_o,
   input wire logic [15:0] pe_gpio_out_i,
   input wire logic [13:0] pe_timer_sel_i,
   input wire logic [13:0] pe_timer_out_i,
   input wire logic        dma_ch0_acknowledge_out_i,
   input wire logic        dma_ch1_acknowledge_out_i,
   input wire logic        address_hold_out_i,
   input wire logic [15:0] pe_pin_o,
   input wire logic [15:0] pe_pin_oe_o
);
   // Mirror of the registers, the mode pins and two saturating cycle counters.
   typedef struct packed {
      logic [6:0]  pd;
      logic [15:0] dir;
      logic [3:0]  fs;
      logic [1:0]  mode;
      logic [2:0]  age;
      logic [2:0]  up;
   } pdesel_mon_type;
   pdesel_mon_type st_r;
   pdesel_mon_type st_nxt;
   logic           sc;
   logic           e15;
   logic           e14;
   logic [6:0]     pd_sel;

   // Next mirror state; age restarts whenever the mode pins move.
   always_comb begin
      st_nxt = st_r;
      if (reg_wr_i && reg_addr_i == `PDESEL_ADDR_PD_FS) begin
         st_nxt.pd = reg_wdata_i[6:0];
      end
      if (reg_wr_i && reg_addr_i == `PDESEL_ADDR_PE_DIR) begin
         st_nxt.dir = reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `PDESEL_ADDR_PE_FS1) begin
         st_nxt.fs = reg_wdata_i[15:12];
      end
      st_nxt.mode = op_mode_pins_i;
      st_nxt.age = (op_mode_pins_i != st_r.mode) ? 3'h0 : st_r.age + {2'h0, st_r.age != 3'h7};
      st_nxt.up = st_r.up + {2'h0, st_r.up != 3'h7};
   end

   // Mirror register, cleared by the power-on reset like the slice.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Expected routing once the synchronised mode has settled.
   assign sc = st_r.mode == `PDESEL_MODE_SINGLE;
   assign pd_sel = sc ? 7'h00 : (st_r.mode[1] ? st_r.pd : 7'h7F);
   assign e15 = !sc && st_r.fs[3:2] == `PDESEL_CODE_DACK;
   assign e14 = !sc && (st_r.fs[1:0] == `PDESEL_CODE_DACK || st_r.fs[1:0] == `PDESEL_CODE_AH);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   // A read returns the mirrored word in the next cycle only.
   property rd_gives(logic [3:0] a, logic [15:0] v);
      reg_rd_i && reg_addr_i == a |=> reg_rdata_o == v;
   endproperty

   pd_route_a: assert property (
      st_r.age > 3'h3 |-> pd_bus_sel_o == pd_sel)
      else $error("port D routing wrong for mode and mode bits");
   pd_pin_a: assert property (st_r.up > 3'h1 |-> pd_pin_o ==
      ((pd_bus_sel_o & $past(pd_bus_out_i)) | (~pd_bus_sel_o & $past(pd_gpio_out_i))))
      else $error("port D pin value not from selected source");
   pe_low_a: assert property (
      st_r.up > 3'h1 |-> pe_pin_oe_o[13:0] == st_r.dir[13:0] &&
      pe_pin_o[13:0] == (($past(pe_timer_sel_i) & $past(pe_timer_out_i)) |
      (~$past(pe_timer_sel_i) & $past(pe_gpio_out_i[13:0]))))
      else $error("port E low pin drive wrong");
   pe15_a: assert property (
      st_r.age > 3'h3 |-> pe_pin_oe_o[15] == (e15 || st_r.dir[15]) &&
      pe_pin_o[15] == (e15 ? $past(dma_ch1_acknowledge_out_i) : $past(pe_gpio_out_i[15])))
      else $error("port E pin 15 routing wrong");
   pe14_a: assert property (
      st_r.age > 3'h3 |-> pe_pin_oe_o[14] == (e14 || st_r.dir[14]) &&
      pe_pin_o[14] == (!e14 ? $past(pe_gpio_out_i[14]) : st_r.fs[0] ?
      $past(address_hold_out_i) : $past(dma_ch0_acknowledge_out_i)))
      else $error("port E pin 14 routing wrong");
   rd_pd_a: assert property (rd_gives(`PDESEL_ADDR_PD_FS, {9'h000, st_r.pd}))
      else $error("port D function read wrong");
   rd_dir_a: assert property (rd_gives(`PDESEL_ADDR_PE_DIR, st_r.dir))
      else $error("port E direction read wrong");
   rd_fs1_a: assert property (
      rd_gives(`PDESEL_ADDR_PE_FS1, {st_r.fs, 12'h000}))
      else $error("port E upper function read wrong");
   rd_idle_a: assert property (!(reg_rd_i && (reg_addr_i == `PDESEL_ADDR_PD_FS ||
      reg_addr_i == `PDESEL_ADDR_PE_DIR || reg_addr_i == `PDESEL_ADDR_PE_FS1)) |=>
      reg_rdata_o == 16'h0000)
      else $error("read data not zero outside a mapped read");

   // Main scenarios reached.
   cover property (reg_wr_i && reg_addr_i == `PDESEL_ADDR_PE_FS1 && reg_wdata_i[15:14] == 2'h2);
   cover property (st_r.age > 3'h3 && sc && st_r.fs[1:0] == `PDESEL_CODE_AH);
   cover property (reg_rd_i && reg_addr_i == 4'h6);
endmodule

bind pdesel_top pdesel_monitor pdesel_monitor_inst (
   .clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .op_mode_pins_i, .pd_gpio_out_i, .pd_bus_out_i, .pd_pin_o, .pd_bus_sel_o, .pe_gpio_out_i,
   .pe_timer_sel_i, .pe_timer_out_i, .dma_ch0_acknowledge_out_i, .dma_ch1_acknowledge_out_i,
   .address_hold_out_i, .pe_pin_o, .pe_pin_oe_o
);

//--- tb/pdesel_board.sv
// Purpose: Board model resolving each pin from the slice's drive and the board level.
// Assumes: Board sources are weak, so the slice wins wherever it drives.
// Notes:   Contention is not modelled.
`timescale 1ns/1ps

module pdesel_board (
   input  wire logic [6:0]  pd_out_i,
   input  wire logic [6:0]  pd_oe_i,
   input  wire logic [6:0]  pd_ext_i,
   input  wire logic [15:0] pe_out_i,
   input  wire logic [15:0] pe_oe_i,
   input  wire logic [15:0] pe_ext_i,
   output logic      [6:0]  pd_pin_o,
   output logic      [15:0] pe_pin_o
);
   // A wire shows the slice's value where enabled, else the board's own level.
   assign pd_pin_o = (pd_oe_i & pd_out_i) | (~pd_oe_i & pd_ext_i);
   assign pe_pin_o = (pe_oe_i & pe_out_i) | (~pe_oe_i & pe_ext_i);
endmodule

//--- tb/pdesel_bench.sv
// Purpose: Self-checking bench for the pin function slice.
// Assumes: Register port with read data in the cycle after the strobe.
// Notes:   Mode changes wait for the mode pin synchroniser to settle.
`timescale 1ns/1ps
`include "pdesel_cfg.svh"

module pdesel_bench;
   logic        clk_i, arst_n_i, reg_wr_i, reg_rd_i, pd_bus_drive_i;
   logic        dma_ch0_acknowledge_out_i, dma_ch1_acknowledge_out_i, address_hold_out_i;
   logic [1:0]  op_mode_pins_i;
   logic [3:0]  reg_addr_i, fs_m;
   logic [6:0]  pd_pin_i, pd_gpio_out_i, pd_gpio_dir_i, pd_bus_out_i, pd_ext, pd_m;
   logic [6:0]  pd_pin_o, pd_pin_oe_o, pd_gpio_in_o, pd_bus_in_o, pd_bus_sel_o;
   logic [13:0] pe_timer_sel_i, pe_timer_out_i, pe_timer_in_o;
   logic [15:0] reg_wdata_i, reg_rdata_o, pe_pin_i, pe_gpio_out_i, pe_ext, dir_m;
   logic [15:0] pe_pin_o, pe_pin_oe_o, pe_gpio_in_o;
   int          n_fail, num_checks, cyc;

   pdesel_top pdesel_top_inst (.clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .op_mode_pins_i, .pd_pin_i, .pd_gpio_out_i, .pd_gpio_dir_i,
      .pd_bus_out_i, .pd_bus_drive_i, .pd_pin_o, .pd_pin_oe_o, .pd_gpio_in_o, .pd_bus_in_o,
      .pd_bus_sel_o, .pe_pin_i, .pe_gpio_out_i, .pe_timer_sel_i, .pe_timer_out_i,
      .dma_ch0_acknowledge_out_i, .dma_ch1_acknowledge_out_i, .address_hold_out_i,
      .pe_pin_o, .pe_pin_oe_o, .pe_gpio_in_o, .pe_timer_in_o);

   pdesel_board pdesel_board_inst (.pd_out_i(pd_pin_o), .pd_oe_i(pd_pin_oe_o),
      .pd_ext_i(pd_ext), .pe_out_i(pe_pin_o), .pe_oe_i(pe_pin_oe_o), .pe_ext_i(pe_ext),
      .pd_pin_o(pd_pin_i), .pe_pin_o(pe_pin_i));

   // Prints the verdict and ends the run.
   task automatic summarize();
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Compares one value and reports a mismatch.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle register write.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask

   // One-cycle register read; the data is checked in the following cycle.
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(reg_rdata_o, exp);
   endtask

   // Port D routing, drive and pin readback; port E is all inputs whenever this runs.
   task automatic chk_pd();
      logic [6:0] sel, oe, lvl;
      sel = op_mode_pins_i == `PDESEL_MODE_SINGLE ? 7'h00 : (op_mode_pins_i[1] ? pd_m : 7'h7F);
      oe = (sel & {7{pd_bus_drive_i}}) | (~sel & pd_gpio_dir_i);
      lvl = (oe & ((sel & pd_bus_out_i) | (~sel & pd_gpio_out_i))) | (~oe & pd_ext);
      chk({9'h000, pd_bus_sel_o}, {9'h000, sel});
      chk({9'h000, pd_pin_oe_o}, {9'h000, oe});
      chk({9'h000, pd_gpio_in_o}, {9'h000, lvl});
      chk({9'h000, pd_bus_in_o}, {9'h000, lvl & sel});
      chk(pe_gpio_in_o, pe_ext);
      chk({2'h0, pe_timer_in_o}, {2'h0, pe_ext[13:0] & pe_timer_sel_i});
   endtask

   // Port E drive and enable for the current registers and mode.
   task automatic chk_pe();
      logic [15:0] eo, ee;
      logic        sc;
      #1;
      sc = op_mode_pins_i == `PDESEL_MODE_SINGLE;
      eo = pe_gpio_out_i;
      eo[13:0] = (pe_timer_sel_i & pe_timer_out_i) | (~pe_timer_sel_i & eo[13:0]);
      ee = dir_m;
      if (!sc && fs_m[3:2] == `PDESEL_CODE_DACK) begin
         eo[15] = dma_ch1_acknowledge_out_i;
         ee[15] = 1'b1;
      end
      if (!sc && (fs_m[1:0] == `PDESEL_CODE_DACK || fs_m[1:0] == `PDESEL_CODE_AH)) begin
         eo[14] = fs_m[0] ? address_hold_out_i : dma_ch0_acknowledge_out_i;
         ee[14] = 1'b1;
      end
      chk(pe_pin_o, eo);
      chk(pe_pin_oe_o, ee);
   endtask

   // 40 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Hang guard.
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         $display("BAD %0t timeout", $time);
         summarize();
      end
   end

   // Main sequence.
   initial begin
      {arst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
      {n_fail, num_checks, cyc, dir_m, fs_m, pd_m} = '0;
      op_mode_pins_i = `PDESEL_MODE_ROM_ON;
      pd_gpio_out_i = 7'h4C;
      pd_gpio_dir_i = 7'h0F;
      pd_bus_out_i = 7'h33;
      pd_bus_drive_i = 1'b1;
      pd_ext = 7'h2A;
      pe_gpio_out_i = 16'h2A5A;
      pe_ext = 16'hC33C;
      pe_timer_sel_i = 14'h00FF;
      pe_timer_out_i = 14'h3C3C;
      dma_ch0_acknowledge_out_i = 1'b1;
      dma_ch1_acknowledge_out_i = 1'b1;
      address_hold_out_i = 1'b0;
      repeat (12) @(posedge clk_i);
      arst_n_i <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         rd(`PDESEL_ADDR_PD_FS, 16'h0000);
         rd(`PDESEL_ADDR_PE_DIR, 16'h0000);
         rd(`PDESEL_ADDR_PE_FS1, 16'h0000);
         chk_pe();
         wr(`PDESEL_ADDR_PD_FS, 16'hFFFF);
         rd(`PDESEL_ADDR_PD_FS, 16'h007F);
         wr(`PDESEL_ADDR_PE_DIR, 16'hA5C3);
         dir_m = 16'hA5C3;
         rd(`PDESEL_ADDR_PE_DIR, 16'hA5C3);
         wr(`PDESEL_ADDR_PE_FS1, 16'hF000);
         fs_m = 4'hF;
         rd(`PDESEL_ADDR_PE_FS1, 16'hF000);
         chk_pe();
         wr(4'h6, 16'hFFFF);
         rd(4'h6, 16'h0000);
         rd(`PDESEL_ADDR_PE_DIR, 16'hA5C3);
         @(posedge clk_i);
         arst_n_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         arst_n_i <= 1'b1;
         {dir_m, fs_m} = '0;
      end
      wr(`PDESEL_ADDR_PD_FS, 16'h0055);
      pd_m = 7'h55;
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_i);
         op_mode_pins_i <= 2'(m);
         pd_bus_drive_i <= m[0];
         repeat (8) @(posedge clk_i);
         #1;
         chk_pd();
      end
      wr(`PDESEL_ADDR_PE_DIR, 16'h8001);
      dir_m = 16'h8001;
      for (int m = 2; m < 4; m++) begin
         @(posedge clk_i);
         op_mode_pins_i <= 2'(m);
         repeat (6) @(posedge clk_i);
         for (int c = 0; c < 4; c++) begin
            fs_m = {2'(c), 2'(c)};
            wr(`PDESEL_ADDR_PE_FS1, {fs_m, 12'h000});
            chk_pe();
            rd(`PDESEL_ADDR_PE_FS1, {fs_m, 12'h000});
         end
      end
      summarize();
   end
endmodule
